// file: verilog/isp_device.sv
// Notes on behaviour
// - All slave functions, no general call.
// - Detect start and stop, raise interrupts.
// - Standard-mode timing, 7-bit and 10-bit addressing.
// - Nothing works until enable bit 5 set.
// - Mode field bits 3:0 selects five modes.
// - Pins open drain; slave modes drive only while direction is input, firmware master only while output.
// - Software sets direction bits 4:3 to input.
// - Status register read-only, reports transfer state.
// - Shift register plus buffer give double buffering.
// - Full byte copied to buffer, flag set.
// - Byte while buffer unread sets overflow, discarded.
// - Ten-bit: software loads high address pattern first.
// - After high match, software loads low byte.
// - Matching write address clears direction status bit.
// - Matching address byte goes into buffer.
// - Overflow present: no acknowledge, data line released.
// - Overflow means buffer full or overflow flag.
// - Interrupt raised for every byte transferred.
// - Software alone clears the port interrupt flag.
// - Firmware master mode: address logic idle.
`timescale 1ns/100ps
module isp_device
  import isp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o,
  // Bus pins
  isp_bus_if.device bus
);
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [7:0] ctrl_q;
  logic [7:0] dir_q;
  logic [7:0] addr_q;
  logic [7:0] buf_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic bf_q;
  logic ua_q;
  logic rw_q;
  logic s_q;
  logic p_q;
  logic da_q;
  logic irq_q;
  logic ten_ok_q;
  logic nack_q;
  logic sda_drv_q;
  logic [3:0] cnt_q;
  isp_dev_state_type state_q;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [3:0] mode;
  logic slave_on;
  logic fw_on;
  logic ten_mode;
  logic ss_int;
  logic ovf;
  logic byte_end;
  logic hi_match;
  logic hit;
  logic do_ack;
  logic ov_set;
  logic buf_load;
  logic byte_irq;
  logic buf_rd;

  function automatic logic slave_mode(input logic [3:0] m);
    slave_mode = (m == MODE_S7) || (m == MODE_S10) || (m == MODE_S7I) || (m == MODE_S10I);
  endfunction

  assign scl = scl_sync_q[1];
  assign sda = sda_sync_q[1];
  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;
  assign start_det = scl && scl_prev_q && sda_prev_q && !sda;
  assign stop_det = scl && scl_prev_q && !sda_prev_q && sda;
  assign mode = ctrl_q[3:0];
  assign slave_on = ctrl_q[CTRL_EN_BIT] && slave_mode(mode);
  assign fw_on = ctrl_q[CTRL_EN_BIT] && (mode == MODE_FWM);
  assign ten_mode = (mode == MODE_S10) || (mode == MODE_S10I);
  assign ss_int = (mode == MODE_S7I) || (mode == MODE_S10I);
  assign ovf = bf_q || ctrl_q[CTRL_OV_BIT];
  assign byte_end = slave_on && scl_fall && (cnt_q == 4'h8);
  assign hi_match = (sr_q[7:3] == TEN_BIT_HEAD) && (sr_q[7:1] == addr_q[7:1]);
  assign buf_rd = reg_re_i && (reg_addr_i == REG_BUF);

  // Address and data recognition; no general call decode
  always_comb begin
    hit = 1'b0;
    case (state_q)
      DS_ADDR: begin
        if (ten_mode) begin
          hit = hi_match && (!sr_q[0] || ten_ok_q);
        end else begin
          hit = (sr_q[7:1] == addr_q[7:1]);
        end
      end
      DS_ADDR2: hit = (sr_q == addr_q);
      DS_RX: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign do_ack = byte_end && hit && !ovf;
  assign buf_load = do_ack;
  assign ov_set = byte_end && hit && ovf && (state_q != DS_TX);
  assign byte_irq = byte_end && (hit || state_q == DS_TX);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_prev_q <= scl;
      sda_prev_q <= sda;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      dir_q <= DIR_RST;
      addr_q <= ADDR_RST;
    end else begin
      if (reg_we_i && reg_addr_i == REG_CTRL) begin
        ctrl_q <= reg_wdata_i;
      end
      if (ov_set) begin
        ctrl_q[CTRL_OV_BIT] <= 1'b1;
      end
      if (reg_we_i && reg_addr_i == REG_DIR) begin
        dir_q <= reg_wdata_i;
      end
      if (reg_we_i && reg_addr_i == REG_ADDR) begin
        addr_q <= reg_wdata_i;
      end
    end
  end

  // Buffer, full flag and port interrupt flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      buf_q <= 8'h00;
      bf_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (reg_we_i && reg_addr_i == REG_BUF) begin
        buf_q <= reg_wdata_i;
      end
      if (buf_rd) begin
        bf_q <= 1'b0;
      end
      if (buf_load) begin
        buf_q <= sr_q;
        bf_q <= 1'b1;
      end
      if (reg_we_i && reg_addr_i == REG_PIR && !reg_wdata_i[PIR_IF_BIT]) begin
        irq_q <= 1'b0;
      end
      if (byte_irq || (slave_on && ss_int && (start_det || stop_det))) begin
        irq_q <= 1'b1;
      end
    end
  end

  // Bit counter and shift register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
    end else if (!slave_on || start_det) begin
      cnt_q <= 4'h0;
    end else if (scl_rise && state_q != DS_IDLE) begin
      if (cnt_q < 4'h8) begin
        sr_q <= {sr_q[6:0], sda};
      end
      if (cnt_q < 4'h9) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else if (scl_fall && cnt_q == 4'h9) begin
      cnt_q <= 4'h0;
    end
  end

  // Transfer sequencing and status
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= DS_IDLE;
      ua_q <= 1'b0;
      rw_q <= 1'b0;
      s_q <= 1'b0;
      p_q <= 1'b0;
      da_q <= 1'b0;
      ten_ok_q <= 1'b0;
      nack_q <= 1'b0;
      sda_drv_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (!slave_on) begin
      state_q <= DS_IDLE;
      sda_drv_q <= 1'b0;
      ten_ok_q <= 1'b0;
    end else if (start_det) begin
      state_q <= DS_ADDR;
      s_q <= 1'b1;
      p_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= DS_IDLE;
      s_q <= 1'b0;
      p_q <= 1'b1;
      ten_ok_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else if (scl_rise && state_q == DS_TX && cnt_q == 4'h8) begin
      nack_q <= sda;
    end else if (byte_end) begin
      sda_drv_q <= do_ack;
      if (state_q != DS_TX && hit) begin
        da_q <= (state_q == DS_RX);
      end
      if (state_q != DS_TX) begin
        nack_q <= 1'b0;
      end
      case (state_q)
        DS_ADDR: begin
          if (!hit) begin
            state_q <= DS_IDLE;
          end else if (sr_q[0]) begin
            rw_q <= 1'b1;
            state_q <= DS_TX;
          end else begin
            rw_q <= 1'b0;
            ua_q <= ten_mode;
            state_q <= ten_mode ? DS_ADDR2 : DS_RX;
          end
        end
        DS_ADDR2: begin
          ua_q <= 1'b0;
          ten_ok_q <= hit;
          state_q <= hit ? DS_RX : DS_IDLE;
        end
        default: state_q <= state_q;
      endcase
    end else if (scl_fall && cnt_q == 4'h9) begin
      sda_drv_q <= 1'b0;
      if (state_q == DS_TX) begin
        if (nack_q) begin
          state_q <= DS_IDLE;
        end else begin
          sda_drv_q <= !buf_q[7];
          tx_q <= {buf_q[6:0], 1'b1};
        end
      end
    end else if (scl_fall && state_q == DS_TX && cnt_q < 4'h8 && cnt_q != 4'h0) begin
      sda_drv_q <= !tx_q[7];
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // Pins and read data
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus.dev_scl_o <= 1'b0;
      bus.dev_sda_o <= 1'b0;
      bus.dev_scl_oe <= 1'b0;
      bus.dev_sda_oe <= 1'b0;
      reg_rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      bus.dev_scl_o <= 1'b0;
      bus.dev_sda_o <= 1'b0;
      bus.dev_scl_oe <= fw_on && !dir_q[DIR_SCL_BIT];
      bus.dev_sda_oe <= (slave_on && dir_q[DIR_SDA_BIT] && sda_drv_q) || (fw_on && !dir_q[DIR_SDA_BIT]);
      irq_o <= irq_q;
      if (reg_re_i) begin
        if (reg_addr_i == REG_CTRL) begin
          reg_rdata_o <= ctrl_q;
        end else if (reg_addr_i == REG_STAT) begin
          reg_rdata_o <= {2'b00, da_q, p_q, s_q, rw_q, ua_q, bf_q};
        end else if (reg_addr_i == REG_BUF) begin
          reg_rdata_o <= buf_q;
        end else if (reg_addr_i == REG_ADDR) begin
          reg_rdata_o <= addr_q;
        end else if (reg_addr_i == REG_DIR) begin
          reg_rdata_o <= dir_q;
        end else if (reg_addr_i == REG_PIR) begin
          reg_rdata_o <= {4'h0, irq_q, 3'b000};
        end else begin
          reg_rdata_o <= 8'h00;
        end
      end
    end
  end
endmodule

// file: verilog/isp_pkg.sv
package isp_pkg;
  // Clock and link timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int QTR_BIT_NS = 2500;
  localparam int QTR_CYC = (QTR_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QTR_CNT_W = $clog2(QTR_CYC + 1);

  // Device register indexes
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_BUF = 3'h2;
  localparam logic [2:0] REG_ADDR = 3'h3;
  localparam logic [2:0] REG_DIR = 3'h4;
  localparam logic [2:0] REG_PIR = 3'h5;

  // Field positions
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_OV_BIT = 6;
  localparam int ST_BF_BIT = 0;
  localparam int ST_UA_BIT = 1;
  localparam int ST_RW_BIT = 2;
  localparam int ST_S_BIT = 3;
  localparam int ST_P_BIT = 4;
  localparam int ST_DA_BIT = 5;
  localparam int PIR_IF_BIT = 3;
  localparam int DIR_SCL_BIT = 3;
  localparam int DIR_SDA_BIT = 4;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // Mode field encodings
  localparam logic [3:0] MODE_S7 = 4'h6;
  localparam logic [3:0] MODE_S10 = 4'h7;
  localparam logic [3:0] MODE_S7I = 4'hE;
  localparam logic [3:0] MODE_S10I = 4'hF;
  localparam logic [3:0] MODE_FWM = 4'hB;
  localparam logic [4:0] TEN_BIT_HEAD = 5'h1E;

  // Bus controller register offsets and fields
  localparam logic [11:0] M_CMD_OFS = 12'h000;
  localparam logic [11:0] M_DATA_OFS = 12'h004;
  localparam logic [11:0] M_STAT_OFS = 12'h008;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_WR_BIT = 2;
  localparam int CMD_RD_BIT = 3;
  localparam int CMD_ACK_BIT = 4;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_ADDR2 = 3'b010,
    DS_RX = 3'b011,
    DS_TX = 3'b100
  } isp_dev_state_type;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_START = 2'b01,
    MS_BIT = 2'b10,
    MS_STOP = 2'b11
  } isp_mst_state_type;
endpackage

// file: verilog/isp_bus_if.sv
`timescale 1ns/100ps
interface isp_bus_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic mst_scl_o;
  logic mst_scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wired level, pulled up when nobody drives low
  assign scl = !((dev_scl_oe && !dev_scl_o) || (mst_scl_oe && !mst_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (mst_sda_oe && !mst_sda_o));

  modport device (input scl, input sda, output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
  modport master (input scl, input sda, output mst_scl_o, output mst_scl_oe, output mst_sda_o, output mst_sda_oe);
endinterface

// file: verilog/isp_master.sv
`timescale 1ns/100ps
module isp_master
  import isp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Bus pins
  isp_bus_if.master bus
);
  logic [1:0] sda_sync_q;
  logic [QTR_CNT_W-1:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [8:0] rx_q;
  logic [7:0] data_q;
  logic start_pend_q;
  logic byte_pend_q;
  logic stop_pend_q;
  logic rd_q;
  logic ack_q;
  logic nack_q;
  isp_mst_state_type state_q;
  logic tick;
  logic busy;
  logic acc;
  logic mapped;

  assign tick = (qcnt_q == QTR_CNT_W'(QTR_CYC - 1));
  assign busy = start_pend_q || byte_pend_q || stop_pend_q || (state_q != MS_IDLE);
  assign acc = psel_i && penable_i && pready_o;
  assign mapped = (paddr_i == M_CMD_OFS) || (paddr_i == M_DATA_OFS) || (paddr_i == M_STAT_OFS);

  // APB: one wait-free access phase, answer registered in setup
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      if (psel_i && !penable_i) begin
        if (paddr_i == M_DATA_OFS) begin
          prdata_o <= {24'h00_0000, rx_q[8:1]};
        end else if (paddr_i == M_STAT_OFS) begin
          prdata_o <= {30'h0000_0000, nack_q, busy};
        end else begin
          prdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sda_sync_q <= 2'b11;
      qcnt_q <= '0;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      qcnt_q <= tick ? '0 : qcnt_q + 1'b1;
    end
  end

  // Command intake and bit engine
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= MS_IDLE;
      ph_q <= 2'b00;
      bit_q <= 4'h0;
      tx_q <= 9'h1FF;
      rx_q <= 9'h000;
      data_q <= 8'h00;
      start_pend_q <= 1'b0;
      byte_pend_q <= 1'b0;
      stop_pend_q <= 1'b0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      bus.mst_scl_o <= 1'b0;
      bus.mst_sda_o <= 1'b0;
      bus.mst_scl_oe <= 1'b0;
      bus.mst_sda_oe <= 1'b0;
    end else begin
      if (acc && pwrite_i && paddr_i == M_DATA_OFS) begin
        data_q <= pwdata_i[7:0];
      end
      if (acc && pwrite_i && paddr_i == M_CMD_OFS && !busy) begin
        start_pend_q <= pwdata_i[CMD_START_BIT];
        stop_pend_q <= pwdata_i[CMD_STOP_BIT];
        byte_pend_q <= pwdata_i[CMD_WR_BIT] || pwdata_i[CMD_RD_BIT];
        rd_q <= pwdata_i[CMD_RD_BIT];
        ack_q <= pwdata_i[CMD_ACK_BIT];
      end
      if (tick) begin
        ph_q <= ph_q + 2'b01;
        case (state_q)
          MS_IDLE: begin
            ph_q <= 2'b00;
            if (start_pend_q) begin
              start_pend_q <= 1'b0;
              state_q <= MS_START;
            end else if (byte_pend_q) begin
              byte_pend_q <= 1'b0;
              bit_q <= 4'h0;
              tx_q <= rd_q ? {8'hFF, !ack_q} : {data_q, 1'b1};
              state_q <= MS_BIT;
            end else if (stop_pend_q) begin
              stop_pend_q <= 1'b0;
              state_q <= MS_STOP;
            end
          end
          MS_START: begin
            case (ph_q)
              2'b00: bus.mst_sda_oe <= 1'b0;
              2'b01: bus.mst_scl_oe <= 1'b0;
              2'b10: bus.mst_sda_oe <= 1'b1;
              default: begin
                bus.mst_scl_oe <= 1'b1;
                state_q <= MS_IDLE;
              end
            endcase
          end
          MS_BIT: begin
            case (ph_q)
              2'b00: begin
                bus.mst_sda_oe <= !tx_q[8];
                tx_q <= {tx_q[7:0], 1'b1};
              end
              2'b01: bus.mst_scl_oe <= 1'b0;
              2'b10: rx_q <= {rx_q[7:0], sda_sync_q[1]};
              default: begin
                bus.mst_scl_oe <= 1'b1;
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  bus.mst_sda_oe <= 1'b0;
                  nack_q <= rx_q[0];
                  state_q <= MS_IDLE;
                end
              end
            endcase
          end
          default: begin
            case (ph_q)
              2'b00: bus.mst_sda_oe <= 1'b1;
              2'b01: bus.mst_scl_oe <= 1'b0;
              2'b10: bus.mst_sda_oe <= 1'b0;
              default: state_q <= MS_IDLE;
            endcase
          end
        endcase
      end
    end
  end
endmodule

// file: testbench/isp_asserts.sv
`timescale 1ns/100ps
module isp_asserts (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Wire signals
  input wire logic dev_scl_o,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic mst_scl_o,
  input wire logic mst_sda_o,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // Acknowledge set up while the clock is low
  sequence ack_setup;
    (dev_sda_oe && !scl) [*8];
  endsequence
  sequence ack_release;
    ##[1:1000] !dev_sda_oe;
  endsequence

  AST_OPEN_DRAIN: assert property (!dev_scl_o && !dev_sda_o && !mst_scl_o && !mst_sda_o)
    else $error("pin driven high");
  AST_ACK_SETUP: assert property ($rose(dev_sda_oe) |-> ack_setup)
    else $error("acknowledge not set up while clock low");
  AST_ACK_BOUNDED: assert property ($rose(dev_sda_oe) |-> ack_release)
    else $error("data line held too long");
  AST_ACK_FALL_LOW: assert property ($fell(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("acknowledge released while clock high");
  AST_SDA_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device moved data line while clock high");
  AST_START_CLOCKS: assert property (scl && $fell(sda) |-> ##[1:1000] !scl)
    else $error("no clock after start");
  AST_STOP_IDLE: assert property (scl && $rose(sda) |-> scl [*8])
    else $error("clock pulled right after stop");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %0t: got %h want %h", $time, (a), (e)); end end
module tb_top
  import isp_pkg::*;
;
  logic ref_clk_i;
  logic rst_i;
  logic [2:0] reg_addr_i;
  logic reg_we_i;
  logic reg_re_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic irq_o;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  int n_mismatch;
  int cmp_count;
  logic [31:0] seed;
  logic [31:0] r;
  logic e;
  logic nk;
  logic [7:0] d;
  logic [7:0] d2;
  logic [7:0] b;
  logic [6:0] own;
  logic [9:0] a10;
  logic [3:0] mode;

  isp_bus_if bus();
  isp_device u_isp_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .bus(bus));
  isp_master u_isp_master (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .bus(bus));
  isp_asserts u_isp_asserts (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dev_scl_o(bus.dev_scl_o),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .mst_scl_o(bus.mst_scl_o),
    .mst_sda_o(bus.mst_sda_o), .scl(bus.scl), .sda(bus.sda));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_ctrl(input logic [3:0] m, input logic ov);
    return {1'b0, ov, 1'b1, 1'b0, m};
  endfunction
  function automatic logic [7:0] hi_pat(input logic [9:0] a);
    return {TEN_BIT_HEAD, a[9:8], 1'b0};
  endfunction

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic fail_to();
    n_mismatch++;
    $display("unexpected %0t: wait timed out", $time);
    final_report();
  endtask

  task automatic dev_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_we_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic dev_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    @(negedge ref_clk_i);
    v = reg_rdata_o;
  endtask

  // Ready, read data and error are all taken at the rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] rd,
    output logic er);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) fail_to();
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic m_cmd(input int bit_i);
    logic [31:0] rd;
    logic er;
    int n;
    apb(1'b1, M_CMD_OFS, 32'h00000001 << bit_i, rd, er);
    n = 0;
    do begin
      apb(1'b0, M_STAT_OFS, 32'h00000000, rd, er);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (rd[0] !== 1'b0) fail_to();
    nk = rd[1];
  endtask
  task automatic m_byte(input logic [7:0] v);
    logic [31:0] rd;
    logic er;
    apb(1'b1, M_DATA_OFS, {24'h000000, v}, rd, er);
    m_cmd(CMD_WR_BIT);
  endtask

  initial begin
    rst_i = 1'b1;
    reg_addr_i = 3'h0;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_wdata_i = 8'h00;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    seed = 32'h00012D64;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    dev_rd(REG_CTRL, d);
    `CHK(d, CTRL_RST)
    dev_rd(REG_DIR, d);
    `CHK(d, DIR_RST)
    dev_rd(REG_ADDR, d);
    `CHK(d, ADDR_RST)
    dev_rd(3'h6, d);
    `CHK(d, 8'h00)
    apb(1'b1, 12'h0FC, 32'h00000000, r, e);
    `CHK(e, 1'b1)
    own = 7'h10 + 7'(rnd() % 96);
    dev_wr(REG_ADDR, {own, 1'b0});
    m_cmd(CMD_START_BIT);
    m_byte({own, 1'b0});
    `CHK(nk, 1'b1)
    m_cmd(CMD_STOP_BIT);
    for (int i = 0; i < 2; i++) begin
      mode = (i == 0) ? MODE_S7 : MODE_S7I;
      dev_wr(REG_PIR, 8'h00);
      dev_wr(REG_CTRL, exp_ctrl(mode, 1'b0));
      dev_rd(REG_BUF, d);
      `CHK(irq_o, 1'b0)
      m_cmd(CMD_START_BIT);
      dev_rd(REG_STAT, d);
      `CHK(d[ST_S_BIT], 1'b1)
      `CHK(irq_o, 1'(i))
      m_byte({own, 1'b0});
      `CHK(nk, 1'b0)
      dev_rd(REG_STAT, d);
      `CHK(d[ST_DA_BIT:ST_BF_BIT], 6'h09)
      `CHK(irq_o, 1'b1)
      dev_wr(REG_PIR, 8'h00);
      b = 8'(rnd());
      m_byte(b);
      `CHK(nk, 1'b1)
      dev_rd(REG_CTRL, d);
      `CHK(d, exp_ctrl(mode, 1'b1))
      `CHK(irq_o, 1'b1)
      dev_rd(REG_BUF, d);
      `CHK(d, {own, 1'b0})
      dev_wr(REG_CTRL, exp_ctrl(mode, 1'b0));
      b = 8'(rnd());
      m_byte(b);
      `CHK(nk, 1'b0)
      dev_rd(REG_STAT, d);
      `CHK(d[ST_DA_BIT], 1'b1)
      dev_rd(REG_BUF, d);
      `CHK(d, b)
      `CHK(irq_o, 1'b1)
      m_cmd(CMD_STOP_BIT);
      dev_rd(REG_STAT, d);
      `CHK(d[ST_P_BIT], 1'b1)
      dev_wr(REG_STAT, ~d);
      dev_rd(REG_STAT, d2);
      `CHK(d2, d)
      m_cmd(CMD_START_BIT);
      m_byte({own ^ 7'h01, 1'b0});
      `CHK(nk, 1'b1)
      m_cmd(CMD_START_BIT);
      m_byte(8'h00);
      `CHK(nk, 1'b1)
      m_cmd(CMD_STOP_BIT);
      // Slave read with a pattern free of long low runs
      dev_wr(REG_ADDR, 8'hAA);
      m_cmd(CMD_START_BIT);
      m_byte(8'hAB);
      `CHK(nk, 1'b0)
      dev_rd(REG_STAT, d);
      `CHK(d[ST_RW_BIT], 1'b1)
      m_cmd(CMD_RD_BIT);
      apb(1'b0, M_DATA_OFS, 32'h00000000, r, e);
      `CHK(r, 32'h000000AB)
      `CHK(irq_o, 1'b1)
      m_cmd(CMD_STOP_BIT);
      dev_wr(REG_ADDR, {own, 1'b0});
    end
    dev_wr(REG_CTRL, exp_ctrl(MODE_FWM, 1'b0));
    m_cmd(CMD_START_BIT);
    m_byte({own, 1'b0});
    `CHK(nk, 1'b1)
    m_cmd(CMD_STOP_BIT);
    dev_wr(REG_DIR, 8'hF7);
    dev_rd(REG_DIR, d);
    `CHK(bus.scl, 1'b0)
    dev_wr(REG_DIR, DIR_RST);
    dev_rd(REG_DIR, d);
    `CHK(bus.scl, 1'b1)
    for (int i = 0; i < 2; i++) begin
      mode = (i == 0) ? MODE_S10 : MODE_S10I;
      a10 = 10'(rnd());
      dev_wr(REG_ADDR, hi_pat(a10));
      dev_wr(REG_CTRL, exp_ctrl(mode, 1'b0));
      dev_rd(REG_BUF, d);
      m_cmd(CMD_START_BIT);
      m_byte(hi_pat(a10));
      `CHK(nk, 1'b0)
      dev_rd(REG_STAT, d);
      `CHK(d[ST_UA_BIT], 1'b1)
      dev_rd(REG_BUF, d);
      `CHK(d, hi_pat(a10))
      dev_wr(REG_ADDR, a10[7:0]);
      m_byte(a10[7:0]);
      `CHK(nk, 1'b0)
      m_cmd(CMD_STOP_BIT);
    end
    final_report();
  end
endmodule
